/* design/sbf_top.sv */
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/1ps
// Byte FIFO with registered flags
module sbf_fifo #(
   parameter int unsigned WIDTH = 10,
   parameter int unsigned DEPTH = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_ff;
   logic [PW-1:0] rd_ptr_ff;
   logic [PW:0] cnt_ff;
   logic [PW:0] nxt_cnt;
   logic in_ready_ff;
   logic out_valid_ff;
   wire push = in_valid_i && in_ready_ff;
   wire pop = out_valid_ff && out_ready_i;

   // Occupancy after this edge
   always_comb begin
      nxt_cnt = cnt_ff;
      if (push && !pop) begin
         nxt_cnt = cnt_ff + (PW+1)'(1);
      end else if (pop && !push) begin
         nxt_cnt = cnt_ff - (PW+1)'(1);
      end
   end

   // Pointers and flags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff <= '0;
         in_ready_ff <= 1'b1;
         out_valid_ff <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_ff <= PW'(wr_ptr_ff + PW'(1));
         end
         if (pop) begin
            rd_ptr_ff <= PW'(rd_ptr_ff + PW'(1));
         end
         cnt_ff <= nxt_cnt;
         in_ready_ff <= (nxt_cnt != (PW+1)'(DEPTH));
         out_valid_ff <= (nxt_cnt != '0);
      end
   end

   // Storage
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_data_i;
      end
   end

   assign in_ready_o = in_ready_ff;
   assign out_valid_o = out_valid_ff;
   assign out_data_o = mem[rd_ptr_ff];
endmodule

// How it works
// - Every address filter command gets a response unless checksum or identifier is bad.
// - Response word carries 16-bit response code above 16-bit reason code.
// - An all-zero address in an address filter command with enable bit one returns reason code 0x0E08.
// - After the enable command, broadcast frames are filtered by the settings word.
// - Enabled filter with no category selected drops every broadcast frame.
// - Settings word is payload bytes 16 to 19, checksum follows, then padding.
// - Category bit one forwards matching frames, zero drops them.
// - Bit 0 is ARP: broadcast destination and Ethertype 0x0806.
// - The ARP category is always supported.
// - Bit 1 is DHCP client: broadcast, IPv4, UDP, destination port 68.
// - Bit 2 is DHCP server: broadcast, IPv4, UDP, destination port 67.
// - Bit 3 is NetBIOS: broadcast, IPv4, UDP, destination port 137 or 138.
// - Unsupported optional categories read as zero and their frames are dropped.
// - Supported categories are reported in the broadcast capability field.
// - Address type 0 is unicast, 1 multicast, 2 to 7 reserved.
// - Enable bit one loads the indexed filter; zero discards it and stops its use.
module sbf_top #(
   parameter int unsigned NUM_FILT = 8,
   parameter logic [3:0] BCAST_CAP = sbf_pkg::CAP_DEFAULT,
   parameter int unsigned FIFO_DEPTH = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rx_valid_i,
   output logic rx_ready_o,
   input wire sbf_pkg::sbf_byte_t rx_byte_i,
   output logic verdict_valid_o,
   input wire logic verdict_ready_i,
   output sbf_pkg::sbf_verdict_t verdict_o
);
   localparam int unsigned BW = $bits(sbf_pkg::sbf_byte_t);

   // Byte-lane merge for register writes
   function automatic logic [31:0] sbf_lane(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return res;
   endfunction

   // Register state
   logic ack_ff;
   logic [31:0] rdat_ff;
   logic [31:0] word0_ff;
   logic [31:0] word1_ff;
   logic [31:0] rsp_ff;
   logic [7:0] rsp_type_ff;
   logic pend_ff;
   logic bc_en_ff;
   logic [3:0] set_ff;
   logic [47:0] mac_ff [sbf_pkg::MAX_FILT];
   logic [sbf_pkg::MAX_FILT-1:0] mac_en_ff;
   logic [31:0] fwd_cnt_ff;
   logic [31:0] drp_cnt_ff;

   // ARP support is forced on whatever the capability parameter says
   wire [3:0] cap = BCAST_CAP | sbf_pkg::CAT_ARP_MASK;

   // Bus access decode: writes take effect on the edge that sees ack high
   wire wb_req = wb_cyc_i && wb_stb_i;
   wire wb_wr = wb_req && wb_we_i && ack_ff;
   wire hit_cmd = wb_adr_i == sbf_pkg::ADR_CMD;
   wire hit_w0 = wb_adr_i == sbf_pkg::ADR_WORD0;
   wire hit_w1 = wb_adr_i == sbf_pkg::ADR_WORD1;
   wire hit_stat = wb_adr_i == sbf_pkg::ADR_STAT;
   wire cmd_go = wb_wr && hit_cmd && wb_sel_i[0];
   wire cmd_drop = wb_dat_i[sbf_pkg::CMD_CKERR_BIT] || wb_dat_i[sbf_pkg::CMD_IDERR_BIT];
   wire cmd_exec = cmd_go && !cmd_drop;
   wire [7:0] cmd_op = wb_dat_i[7:0];
   wire stat_clr = wb_wr && hit_stat && wb_sel_i[0] && wb_dat_i[sbf_pkg::STAT_PEND_BIT];

   // Address filter command fields: address bytes across both payload words
   wire [47:0] cmd_mac = {word0_ff, word1_ff[31:16]};
   wire [7:0] cmd_idx = word1_ff[sbf_pkg::MAC_IDX_LSB +: 8];
   wire [2:0] cmd_at = word1_ff[sbf_pkg::AT_LSB +: 3];
   wire cmd_en = word1_ff[sbf_pkg::MAC_EN_BIT];
   wire at_ok = (cmd_at == sbf_pkg::AT_UNICAST) || (cmd_at == sbf_pkg::AT_MULTICAST);
   wire idx_ok = (cmd_idx != 8'h00) && (cmd_idx <= 8'(NUM_FILT));
   wire mac_zero = cmd_en && (cmd_mac == 48'h0);
   wire [2:0] filt_sel = 3'(cmd_idx - 8'h01);
   wire is_setmac = cmd_op == sbf_pkg::OP_SET_MAC;
   wire is_bcast = cmd_op == sbf_pkg::OP_BCAST_EN;
   wire mac_write = cmd_exec && is_setmac && !mac_zero && at_ok && idx_ok;

   // Response code and reason for the command being executed
   logic [15:0] nxt_code;
   logic [15:0] nxt_reason;
   always_comb begin
      nxt_code = sbf_pkg::RSP_OK;
      nxt_reason = sbf_pkg::REASON_NONE;
      if (is_setmac) begin
         if (mac_zero) begin
            nxt_code = sbf_pkg::RSP_FAIL;
            nxt_reason = sbf_pkg::REASON_MAC_ZERO;
         end else if (!at_ok || !idx_ok) begin
            nxt_code = sbf_pkg::RSP_FAIL;
            nxt_reason = sbf_pkg::REASON_BAD_PARAM;
         end
      end else if (!is_bcast) begin
         nxt_code = sbf_pkg::RSP_FAIL;
         nxt_reason = sbf_pkg::REASON_UNKNOWN;
      end
   end

   // Bus handshake and read data
   logic [31:0] rmux;
   always_comb begin
      case (wb_adr_i)
         sbf_pkg::ADR_WORD0: rmux = word0_ff;
         sbf_pkg::ADR_WORD1: rmux = word1_ff;
         sbf_pkg::ADR_RSP: rmux = rsp_ff;
         sbf_pkg::ADR_STAT: rmux = {16'h0000, rsp_type_ff, set_ff, 2'b00, bc_en_ff, pend_ff};
         sbf_pkg::ADR_CAP: rmux = {28'h0000000, cap};
         sbf_pkg::ADR_MACEN: rmux = {24'h000000, mac_en_ff};
         sbf_pkg::ADR_FWDCNT: rmux = fwd_cnt_ff;
         sbf_pkg::ADR_DRPCNT: rmux = drp_cnt_ff;
         default: rmux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         rdat_ff <= 32'h00000000;
      end else begin
         ack_ff <= wb_req && !ack_ff;
         rdat_ff <= rmux;
      end
   end

   // Payload words, written by software
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         word0_ff <= 32'h00000000;
         word1_ff <= 32'h00000000;
      end else begin
         if (wb_wr && hit_w0) begin
            word0_ff <= sbf_lane(word0_ff, wb_dat_i, wb_sel_i);
         end
         if (wb_wr && hit_w1) begin
            word1_ff <= sbf_lane(word1_ff, wb_dat_i, wb_sel_i);
         end
      end
   end

   // Response and pending flag; a new response beats a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rsp_ff <= 32'h00000000;
         rsp_type_ff <= 8'h00;
         pend_ff <= 1'b0;
      end else begin
         if (cmd_exec) begin
            rsp_ff <= {nxt_code, nxt_reason};
            rsp_type_ff <= cmd_op | sbf_pkg::OP_RSP_FLAG;
            pend_ff <= 1'b1;
         end else if (stat_clr) begin
            pend_ff <= 1'b0;
         end
      end
   end

   // Broadcast filter enable and settings; unsupported and reserved bits dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bc_en_ff <= 1'b0;
         set_ff <= sbf_pkg::SET_RESET;
      end else if (cmd_exec && is_bcast) begin
         bc_en_ff <= 1'b1;
         set_ff <= word0_ff[3:0] & cap;
      end
   end

   // Address filters: load on enable, discard on disable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mac_en_ff <= '0;
      end else if (mac_write) begin
         mac_en_ff[filt_sel] <= cmd_en;
      end
   end

   always_ff @(posedge clk_i) begin
      if (mac_write) begin
         mac_ff[filt_sel] <= cmd_en ? cmd_mac : 48'h0;
      end
   end

   // Receive byte buffer
   logic fifo_valid;
   logic fifo_ready;
   sbf_pkg::sbf_byte_t fifo_byte;
   logic [BW-1:0] fifo_data;
   logic vld_ff;
   assign fifo_ready = !vld_ff || verdict_ready_i;
   assign fifo_byte = sbf_pkg::sbf_byte_t'(fifo_data);

   sbf_fifo #(
      .WIDTH(BW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(rx_valid_i),
      .in_ready_o(rx_ready_o),
      .in_data_i(rx_byte_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_ready),
      .out_data_o(fifo_data)
   );

   // Header parsing of the byte being consumed
   sbf_pkg::sbf_rx_state_t st_ff;
   sbf_pkg::sbf_hdr_t hdr_ff;
   sbf_pkg::sbf_hdr_t hdr_base;
   sbf_pkg::sbf_hdr_t nxt_hdr;
   logic [6:0] cnt_ff;
   wire take = fifo_valid && fifo_ready;
   wire [7:0] b = fifo_byte.data;
   wire in_frame = fifo_byte.sof || (st_ff == sbf_pkg::RX_FRAME);
   wire [6:0] idx = fifo_byte.sof ? 7'h00 : cnt_ff;
   wire [6:0] port_hi = 7'(sbf_pkg::OFS_DPORT + {1'b0, hdr_base.ihl, 2'b00});
   wire [6:0] nxt_cnt = (idx == sbf_pkg::OFS_MAX) ? idx : 7'(idx + 7'h01);
   assign hdr_base = fifo_byte.sof ? sbf_pkg::HDR_INIT : hdr_ff;

   always_comb begin
      nxt_hdr = hdr_base;
      if (idx < sbf_pkg::OFS_DA_END) begin
         nxt_hdr.da = {hdr_base.da[39:0], b};
         nxt_hdr.bc = hdr_base.bc && (b == sbf_pkg::BCAST_BYTE);
      end
      if (idx == sbf_pkg::OFS_ET_HI) begin
         nxt_hdr.et[15:8] = b;
      end
      if (idx == sbf_pkg::OFS_ET_LO) begin
         nxt_hdr.et[7:0] = b;
      end
      if (idx == sbf_pkg::OFS_IHL) begin
         nxt_hdr.ihl = b[3:0];
      end
      if (idx == sbf_pkg::OFS_PROTO) begin
         nxt_hdr.proto = b;
      end
      if (idx == port_hi) begin
         nxt_hdr.port[15:8] = b;
      end
      if (idx == 7'(port_hi + 7'h01)) begin
         nxt_hdr.port[7:0] = b;
      end
   end

   // Category match on the completed header
   wire bc = nxt_hdr.bc;
   wire ip_udp = bc && (nxt_hdr.et == sbf_pkg::ETH_IPV4) && (nxt_hdr.proto == sbf_pkg::IP_UDP);
   logic [3:0] cat;
   assign cat[sbf_pkg::CAT_ARP] = bc && (nxt_hdr.et == sbf_pkg::ETH_ARP);
   assign cat[sbf_pkg::CAT_DHCPC] = ip_udp && (nxt_hdr.port == sbf_pkg::PORT_DHCPC);
   assign cat[sbf_pkg::CAT_DHCPS] = ip_udp && (nxt_hdr.port == sbf_pkg::PORT_DHCPS);
   assign cat[sbf_pkg::CAT_NETBIOS] = ip_udp && ((nxt_hdr.port == sbf_pkg::PORT_NB_NAME) ||
                                                (nxt_hdr.port == sbf_pkg::PORT_NB_DGRAM));

   // Destination match against enabled address filters
   logic [sbf_pkg::MAX_FILT-1:0] mac_hits;
   for (genvar g = 0; g < sbf_pkg::MAX_FILT; g++) begin : g_hit
      if (g < NUM_FILT) begin : g_on
         assign mac_hits[g] = mac_en_ff[g] && (mac_ff[g] == nxt_hdr.da);
      end else begin : g_off
         assign mac_hits[g] = 1'b0;
      end
   end

   // Forward decision: broadcast needs a selected category when enabled
   wire sel_hit = |(cat & set_ff);
   wire fwd = !bc || !bc_en_ff || sel_hit;
   wire done = take && in_frame && fifo_byte.eof;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= sbf_pkg::RX_IDLE;
         hdr_ff <= sbf_pkg::HDR_INIT;
         cnt_ff <= 7'h00;
      end else if (take) begin
         case (st_ff)
            sbf_pkg::RX_IDLE: begin
               if (fifo_byte.sof && !fifo_byte.eof) begin
                  st_ff <= sbf_pkg::RX_FRAME;
               end
            end
            sbf_pkg::RX_FRAME: begin
               if (fifo_byte.eof) begin
                  st_ff <= sbf_pkg::RX_IDLE;
               end
            end
            default: st_ff <= sbf_pkg::RX_IDLE;
         endcase
         if (in_frame) begin
            hdr_ff <= nxt_hdr;
            cnt_ff <= nxt_cnt;
         end
      end
   end

   // Verdict output and counters
   sbf_pkg::sbf_verdict_t vrd_ff;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vld_ff <= 1'b0;
         vrd_ff <= '0;
         fwd_cnt_ff <= 32'h00000000;
         drp_cnt_ff <= 32'h00000000;
      end else begin
         if (done) begin
            vld_ff <= 1'b1;
            vrd_ff <= '{fwd: fwd, bcast: bc, mac_hit: |mac_hits, cat: cat};
         end else if (verdict_ready_i) begin
            vld_ff <= 1'b0;
         end
         if (done && fwd) begin
            fwd_cnt_ff <= fwd_cnt_ff + 32'h00000001;
         end
         if (done && !fwd) begin
            drp_cnt_ff <= drp_cnt_ff + 32'h00000001;
         end
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;
   assign verdict_valid_o = vld_ff;
   assign verdict_o = vrd_ff;
endmodule

/* design/sbf_pkg.sv */
// Shared constants and carriers of the sideband broadcast filter
package sbf_pkg;
   // Register map, byte addresses on the Wishbone slave
   localparam int unsigned AW = 8;
   localparam logic [7:0] ADR_CMD = 8'h00;
   localparam logic [7:0] ADR_WORD0 = 8'h04;
   localparam logic [7:0] ADR_WORD1 = 8'h08;
   localparam logic [7:0] ADR_RSP = 8'h0C;
   localparam logic [7:0] ADR_STAT = 8'h10;
   localparam logic [7:0] ADR_CAP = 8'h14;
   localparam logic [7:0] ADR_MACEN = 8'h18;
   localparam logic [7:0] ADR_FWDCNT = 8'h1C;
   localparam logic [7:0] ADR_DRPCNT = 8'h20;
   // Command and status register fields
   localparam int unsigned CMD_CKERR_BIT = 8;
   localparam int unsigned CMD_IDERR_BIT = 9;
   localparam int unsigned STAT_PEND_BIT = 0;
   // Command and response type codes
   localparam logic [7:0] OP_SET_MAC = 8'h0E;
   localparam logic [7:0] OP_BCAST_EN = 8'h10;
   localparam logic [7:0] OP_RSP_FLAG = 8'h80;
   localparam logic [15:0] RSP_OK = 16'h0000;
   localparam logic [15:0] RSP_FAIL = 16'h0001;
   localparam logic [15:0] REASON_NONE = 16'h0000;
   localparam logic [15:0] REASON_BAD_PARAM = 16'h0002;
   localparam logic [15:0] REASON_UNKNOWN = 16'h7FFF;
   localparam logic [15:0] REASON_MAC_ZERO = 16'h0E08;
   // Address filter programming fields in the second payload word
   localparam int unsigned MAC_IDX_LSB = 8;
   localparam int unsigned AT_LSB = 5;
   localparam int unsigned MAC_EN_BIT = 0;
   localparam logic [2:0] AT_UNICAST = 3'h0;
   localparam logic [2:0] AT_MULTICAST = 3'h1;
   localparam int unsigned MAX_FILT = 8;
   // Broadcast categories
   localparam int unsigned CAT_W = 4;
   localparam int unsigned CAT_ARP = 0;
   localparam int unsigned CAT_DHCPC = 1;
   localparam int unsigned CAT_DHCPS = 2;
   localparam int unsigned CAT_NETBIOS = 3;
   localparam logic [3:0] CAT_ARP_MASK = 4'h1;
   localparam logic [3:0] CAP_DEFAULT = 4'hF;
   localparam logic [3:0] SET_RESET = 4'h0;
   // Frame field values
   localparam logic [7:0] BCAST_BYTE = 8'hFF;
   localparam logic [15:0] ETH_ARP = 16'h0806;
   localparam logic [15:0] ETH_IPV4 = 16'h0800;
   localparam logic [7:0] IP_UDP = 8'h11;
   localparam logic [15:0] PORT_DHCPC = 16'h0044;
   localparam logic [15:0] PORT_DHCPS = 16'h0043;
   localparam logic [15:0] PORT_NB_NAME = 16'h0089;
   localparam logic [15:0] PORT_NB_DGRAM = 16'h008A;
   // Frame byte offsets
   localparam logic [6:0] OFS_DA_END = 7'h06;
   localparam logic [6:0] OFS_ET_HI = 7'h0C;
   localparam logic [6:0] OFS_ET_LO = 7'h0D;
   localparam logic [6:0] OFS_IHL = 7'h0E;
   localparam logic [6:0] OFS_PROTO = 7'h17;
   localparam logic [6:0] OFS_DPORT = 7'h10;
   localparam logic [6:0] OFS_MAX = 7'h7F;
   // Frame byte on the receive stream
   typedef struct packed {
      logic [7:0] data;
      logic sof;
      logic eof;
   } sbf_byte_t;
   // Header fields gathered while a frame passes
   typedef struct packed {
      logic [47:0] da;
      logic bc;
      logic [15:0] et;
      logic [3:0] ihl;
      logic [7:0] proto;
      logic [15:0] port;
   } sbf_hdr_t;
   localparam sbf_hdr_t HDR_INIT = '{da: 48'h0, bc: 1'b1, et: 16'h0, ihl: 4'h0,
                                     proto: 8'h00, port: 16'h0000};
   // Per-frame verdict
   typedef struct packed {
      logic fwd;
      logic bcast;
      logic mac_hit;
      logic [3:0] cat;
   } sbf_verdict_t;
   typedef enum logic [0:0] {
      RX_IDLE = 1'b0,
      RX_FRAME = 1'b1
   } sbf_rx_state_t;
endpackage

/* sim/sbf_top_monitor.sv */
`timescale 1ns/1ps
// Port-level checks of the broadcast filter top
module sbf_top_monitor #(
   parameter logic [3:0] BCAST_CAP = sbf_pkg::CAP_DEFAULT
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic verdict_valid_o,
   input wire logic verdict_ready_i,
   input wire sbf_pkg::sbf_verdict_t verdict_o
);
   logic wr_ok;
   logic bc_cmd;
   logic en_ff;
   logic [3:0] w0_ff;
   logic [3:0] set_ff;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Decode accepted writes that touch the broadcast setup
   assign wr_ok = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
   assign bc_cmd = wr_ok && wb_adr_i == sbf_pkg::ADR_CMD && wb_dat_i[9:0] == 10'h010;
   // Shadow of the active broadcast settings
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_ff <= 1'b0;
         w0_ff <= 4'h0;
         set_ff <= 4'h0;
      end else begin
         w0_ff <= (wr_ok && wb_adr_i == sbf_pkg::ADR_WORD0) ? wb_dat_i[3:0] : w0_ff;
         en_ff <= en_ff || bc_cmd;
         set_ff <= bc_cmd ? (w0_ff & (BCAST_CAP | 4'h1)) : set_ff;
      end
   end
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   property p_req_ack;
      s_req |=> s_ack_pulse;
   endproperty
   a_req_ack: assert property (p_req_ack)
      else $error("request not answered by a one-cycle ack");
   property p_ack_req;
      wb_ack_o |-> wb_cyc_i && wb_stb_i;
   endproperty
   a_ack_req: assert property (p_ack_req)
      else $error("ack without a request");
   property p_cap_arp;
      wb_ack_o && !wb_we_i && wb_adr_i == sbf_pkg::ADR_CAP |-> wb_dat_o[0];
   endproperty
   a_cap_arp: assert property (p_cap_arp)
      else $error("arp category not reported");
   property p_hold;
      verdict_valid_o && !verdict_ready_i |=> verdict_valid_o && $stable(verdict_o);
   endproperty
   a_hold: assert property (p_hold)
      else $error("verdict changed before taken");
   property p_nonbc;
      verdict_valid_o && !verdict_o.bcast |-> verdict_o.fwd && verdict_o.cat == 4'h0;
   endproperty
   a_nonbc: assert property (p_nonbc)
      else $error("non-broadcast frame filtered");
   property p_onehot;
      verdict_valid_o |-> $onehot0(verdict_o.cat);
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("frame in more than one category");
   property p_bc_filter;
      verdict_valid_o && verdict_o.bcast && en_ff |-> verdict_o.fwd == |(verdict_o.cat & set_ff);
   endproperty
   a_bc_filter: assert property (p_bc_filter)
      else $error("broadcast verdict disagrees with settings");
   property p_bc_open;
      verdict_valid_o && verdict_o.bcast && !en_ff |-> verdict_o.fwd;
   endproperty
   a_bc_open: assert property (p_bc_open)
      else $error("broadcast dropped before filter enabled");
endmodule
bind sbf_top sbf_top_monitor #(.BCAST_CAP(BCAST_CAP)) u_mon (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .verdict_valid_o(verdict_valid_o), .verdict_ready_i(verdict_ready_i),
   .verdict_o(verdict_o));

/* sim/sbf_mc_model.sv */
`timescale 1ns/1ps
// Verdict sink standing for the management controller
module sbf_mc_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic slow_i,
   input wire logic hold_i,
   output logic verdict_ready_o
);
   // Ready at random when slow, low while held
   always_ff @(posedge clk_i) begin
      if (rst_i || hold_i) begin
         verdict_ready_o <= 1'b0;
      end else begin
         verdict_ready_o <= !slow_i || ($urandom % 3 == 0);
      end
   end
endmodule

/* sim/sbf_top_tb.sv */
`timescale 1ns/1ps
// Register traffic, frame stream and verdict checks
module sbf_top_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, r, s;
   logic rx_valid_i = 1'b0, rx_ready_o, verdict_valid_o, verdict_ready_i;
   sbf_pkg::sbf_byte_t rx_byte_i = '0;
   sbf_pkg::sbf_verdict_t verdict_o, got_q[$], exp_q[$];
   logic slow = 1'b0, hold = 1'b0, en_exp = 1'b0, hit_en = 1'b0;
   logic [3:0] set_exp = 4'h0;
   logic [47:0] mac_a;
   int fails = 0, tests_run = 0, n;
   logic [15:0] k_et [8] = '{16'h0806, 16'h0800, 16'h0800, 16'h0800, 16'h0800, 16'h0800,
      16'h0800, 16'h86DD};
   logic [7:0] k_pr [8] = '{8'h00, 8'h11, 8'h11, 8'h11, 8'h11, 8'h11, 8'h06, 8'h11};
   logic [15:0] k_pt [8] = '{16'h0000, 16'h0044, 16'h0043, 16'h0089, 16'h008A, 16'h0035,
      16'h0044, 16'h0044};
   localparam logic [47:0] BC = 48'hFFFF_FFFF_FFFF;
   localparam logic [47:0] NON = 48'h02AA_0000_0001;
   always #2 clk_i = ~clk_i;
   sbf_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i),
      .rx_ready_o(rx_ready_o), .rx_byte_i(rx_byte_i), .verdict_valid_o(verdict_valid_o),
      .verdict_ready_i(verdict_ready_i), .verdict_o(verdict_o));
   sbf_mc_model u_mc (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .hold_i(hold),
      .verdict_ready_o(verdict_ready_i));
   // Collect every verdict the sink takes
   always @(posedge clk_i) begin
      if (verdict_valid_o === 1'b1 && verdict_ready_i === 1'b1) begin
         got_q.push_back(verdict_o);
      end
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tmo(input int k);
      if (k >= 500) begin
         fails++;
         summarize();
      end
   endtask
   // One classic Wishbone cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 500);
      r = wb_dat_o;
      tmo(n);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0);
      check(r, exp);
   endtask
   // Pending flag and type, then response word, then clear
   task automatic rsp(input logic [31:0] exp, input logic [7:0] typ);
      wb(1'b0, sbf_pkg::ADR_STAT, 32'h0);
      check(r & 32'h0000_FF01, {16'h0, typ, 8'h01});
      rdchk(sbf_pkg::ADR_RSP, exp);
      wb(1'b1, sbf_pkg::ADR_STAT, 32'h1);
   endtask
   task automatic bcen(input logic [31:0] v);
      wb(1'b1, sbf_pkg::ADR_WORD0, v);
      wb(1'b1, sbf_pkg::ADR_CMD, 32'h0000_0010);
      en_exp = 1'b1;
      set_exp = v[3:0];
      rsp(32'h0, 8'h90);
   endtask
   task automatic setmac(input logic [47:0] a, input logic [2:0] at, input logic en);
      wb(1'b1, sbf_pkg::ADR_WORD0, a[47:16]);
      wb(1'b1, sbf_pkg::ADR_WORD1, {a[15:0], 8'h01, at, 4'h0, en});
      wb(1'b1, sbf_pkg::ADR_CMD, 32'h0000_000E);
   endtask
   function automatic sbf_pkg::sbf_verdict_t expv(input logic [47:0] da,
      input logic [15:0] et, input logic [7:0] pr, input logic [15:0] pt);
      sbf_pkg::sbf_verdict_t v;
      v = '0;
      v.bcast = (da == BC);
      v.mac_hit = hit_en && da == mac_a;
      if (v.bcast && et == 16'h0806)
         v.cat = 4'h1;
      if (v.bcast && et == 16'h0800 && pr == 8'h11) begin
         v.cat = (pt == 16'h0044) ? 4'h2 : (pt == 16'h0043) ? 4'h4 :
            (pt == 16'h0089 || pt == 16'h008A) ? 4'h8 : 4'h0;
      end
      v.fwd = !v.bcast || !en_exp || |(v.cat & set_exp);
      return v;
   endfunction
   // Send one 40-byte frame of a given kind, IHL 5
   task automatic send(input logic [47:0] da, input int k);
      logic [7:0] b [40];
      int m;
      b = '{default: 8'h00};
      for (int i = 0; i < 6; i++)
         b[i] = da[47-8*i -: 8];
      b[12] = k_et[k][15:8];
      b[13] = k_et[k][7:0];
      b[14] = 8'h45;
      b[23] = k_pr[k];
      b[36] = k_pt[k][15:8];
      b[37] = k_pt[k][7:0];
      exp_q.push_back(expv(da, k_et[k], k_pr[k], k_pt[k]));
      for (int i = 0; i < 40; i++) begin
         rx_valid_i <= 1'b1;
         rx_byte_i <= '{data: b[i], sof: (i == 0), eof: (i == 39)};
         m = 0;
         do begin
            @(posedge clk_i);
            m++;
         end while (rx_ready_o !== 1'b1 && m < 500);
         tmo(m);
      end
      rx_valid_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic drain();
      int m;
      while (exp_q.size() > 0) begin
         m = 0;
         while (got_q.size() == 0 && m < 500) begin
            @(posedge clk_i);
            m++;
         end
         tmo(m);
         check({25'h0, got_q.pop_front()}, {25'h0, exp_q.pop_front()});
      end
   endtask
   // Main sequence
   initial begin
      void'($urandom(94));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rdchk(sbf_pkg::ADR_CAP, 32'h0000_000F);
      rdchk(8'h40, 32'h0);
      for (int k = 0; k < 8; k++)
         send(BC, k);
      drain();
      for (int i = 0; i < 8; i++) begin
         s = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFF_FFF0 : $urandom;
         slow <= i[0];
         bcen(s);
         for (int k = 0; k < 8; k++)
            send(BC, k);
         send(NON, $urandom % 8);
         drain();
      end
      for (int e = 1; e < 3; e++) begin
         wb(1'b1, sbf_pkg::ADR_CMD, {22'h0, e[1:0], 8'h0E});
         rdchk(sbf_pkg::ADR_STAT, {16'h0, 8'h90, set_exp, 4'h2});
      end
      wb(1'b1, sbf_pkg::ADR_CMD, 32'h0000_0033);
      rsp(32'h0001_7FFF, 8'hB3);
      setmac(48'h0, 3'h0, 1'b1);
      rsp(32'h0001_0E08, 8'h8E);
      mac_a = {16'h0200, 32'($urandom)};
      setmac(mac_a, 3'h0, 1'b1);
      rsp(32'h0, 8'h8E);
      hit_en = 1'b1;
      setmac(mac_a, 3'h2, 1'b1);
      rsp(32'h0001_0002, 8'h8E);
      send(mac_a, 1);
      setmac(mac_a, 3'h0, 1'b0);
      rsp(32'h0, 8'h8E);
      hit_en = 1'b0;
      send(mac_a, 1);
      drain();
      hold <= 1'b1;
      fork
         for (int k = 0; k < 3; k++)
            send(BC, k);
         begin
            n = 0;
            while (rx_ready_o !== 1'b0 && n < 400) begin
               @(posedge clk_i);
               n++;
            end
            check({31'h0, rx_ready_o}, 32'h0);
            hold <= 1'b0;
         end
      join
      drain();
      summarize();
   end
endmodule
